//--- common/cwd_pkg.sv
package cwd_pkg;
	localparam int CLK_MHZ = 200;
	localparam real PULSE_MIN_US = 0.5;
	localparam real PULSE_MAX_US = 500.0;
	localparam real GAP_MAX_US = 500.0;
	localparam real HOLD_DLY_US = 40.0;
	localparam real NORM_DLY_US = 35.0;
	localparam real BUSMODE_DLY_US = 10.0;
	localparam real INT_PULSE_US = 10.0;
	localparam real DOM_TOUT_US = 360.0;
	// Least times round up, longest round down
	localparam int PULSE_MIN_CYC = int'($ceil(PULSE_MIN_US * CLK_MHZ));
	localparam int PULSE_MAX_CYC = int'($floor(PULSE_MAX_US * CLK_MHZ));
	localparam int GAP_MAX_CYC = int'($floor(GAP_MAX_US * CLK_MHZ));
	localparam int HOLD_DLY_CYC = int'($ceil(HOLD_DLY_US * CLK_MHZ));
	localparam int NORM_DLY_CYC = int'($ceil(NORM_DLY_US * CLK_MHZ));
	localparam int BUSMODE_DLY_CYC = int'($floor(BUSMODE_DLY_US * CLK_MHZ));
	localparam int INT_PULSE_CYC = int'($floor(INT_PULSE_US * CLK_MHZ));
	localparam int DOM_TOUT_CYC = int'($ceil(DOM_TOUT_US * CLK_MHZ));
	localparam int WAKE_PULSES = 3;
	localparam int CNT_W = 20;
	typedef enum logic [1:0] {
		MODE_STOP = 2'b00,
		MODE_HOLD = 2'b01,
		MODE_NORMAL = 2'b10
	} cwd_mode_t;
	typedef struct packed {
		logic modeValid;
		logic wakeOnly;
		logic active;
	} cwd_bus_cmd_t;
endpackage

//--- design/cwd_can_wake.sv
`timescale 1ns/100ps
module cwd_can_wake #(
	parameter int PULSE_MAX_CYC = cwd_pkg::PULSE_MAX_CYC,
	parameter int GAP_MAX_CYC = cwd_pkg::GAP_MAX_CYC,
	parameter int HOLD_DLY_CYC = cwd_pkg::HOLD_DLY_CYC,
	parameter int NORM_DLY_CYC = cwd_pkg::NORM_DLY_CYC,
	parameter int BUSMODE_DLY_CYC = cwd_pkg::BUSMODE_DLY_CYC,
	parameter int INT_PULSE_CYC = cwd_pkg::INT_PULSE_CYC,
	parameter int DOM_TOUT_CYC = cwd_pkg::DOM_TOUT_CYC
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic busDomPin,
	input wire logic txPin,
	input wire logic chipSelPin,
	input wire logic watchdogService,
	input wire cwd_pkg::cwd_bus_cmd_t busCmd,
	input wire logic busWakeDisable,
	output logic busDrive,
	output logic rxPin,
	output logic wakeFlag,
	output logic intPinN,
	output logic mainRegulatorOutput,
	output logic resetReleased,
	output cwd_pkg::cwd_mode_t mode,
	output logic busActive
);
	localparam logic [cwd_pkg::CNT_W-1:0] P_MIN = cwd_pkg::CNT_W'(cwd_pkg::PULSE_MIN_CYC);
	localparam logic [cwd_pkg::CNT_W-1:0] P_MAX = cwd_pkg::CNT_W'(PULSE_MAX_CYC);
	localparam logic [cwd_pkg::CNT_W-1:0] G_MAX = cwd_pkg::CNT_W'(GAP_MAX_CYC);
	localparam logic [cwd_pkg::CNT_W-1:0] H_DLY = cwd_pkg::CNT_W'(HOLD_DLY_CYC);
	localparam logic [cwd_pkg::CNT_W-1:0] N_DLY = cwd_pkg::CNT_W'(NORM_DLY_CYC);
	localparam logic [cwd_pkg::CNT_W-1:0] B_DLY = cwd_pkg::CNT_W'(BUSMODE_DLY_CYC);
	localparam logic [cwd_pkg::CNT_W-1:0] I_LEN = cwd_pkg::CNT_W'(INT_PULSE_CYC);
	localparam logic [cwd_pkg::CNT_W-1:0] D_TOUT = cwd_pkg::CNT_W'(DOM_TOUT_CYC);

	// Two-flop synchronisers for pin inputs
	logic [1:0] domSync_reg;
	logic [1:0] txSync_reg;
	logic [1:0] csSync_reg;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			domSync_reg <= 2'h0;
			txSync_reg <= 2'h3;
			csSync_reg <= 2'h3;
		end else begin
			domSync_reg <= {domSync_reg[0], busDomPin};
			txSync_reg <= {txSync_reg[0], txPin};
			csSync_reg <= {csSync_reg[0], chipSelPin};
		end
	end
	logic busDom;
	logic txDom;
	logic csHigh;
	assign busDom = domSync_reg[1];
	assign txDom = ~txSync_reg[1];
	assign csHigh = csSync_reg[1];

	// Low-power receiver path; gated out when wake is disabled or bus active
	logic wakeSense;
	assign wakeSense = busDom & ~busWakeDisable & ~busActive;
	logic wakeSense_reg;
	logic csHigh_reg;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wakeSense_reg <= 1'b0;
			csHigh_reg <= 1'b1;
		end else begin
			wakeSense_reg <= wakeSense;
			csHigh_reg <= csHigh;
		end
	end

	// Pulse width measurement, saturating past the upper limit
	logic [cwd_pkg::CNT_W-1:0] width_reg;
	always_ff @(posedge ref_clk) begin
		if (srst || !wakeSense)
			width_reg <= '0;
		else if (width_reg <= P_MAX)
			width_reg <= width_reg + 1'b1;
	end
	logic pulseEnd;
	logic pulseOk;
	logic pulseBad;
	assign pulseEnd = wakeSense_reg & ~wakeSense;
	assign pulseOk = pulseEnd && width_reg > P_MIN && width_reg < P_MAX;
	assign pulseBad = pulseEnd & ~pulseOk;

	// Gap timer and accepted-pulse counter
	logic [cwd_pkg::CNT_W-1:0] gap_reg;
	logic [1:0] pulses_reg;
	logic gapOut;
	logic wakeHit;
	assign gapOut = (pulses_reg != 2'h0) && gap_reg > G_MAX;
	assign wakeHit = pulseOk && pulses_reg == 2'(cwd_pkg::WAKE_PULSES - 1);
	always_ff @(posedge ref_clk) begin
		if (srst || pulseBad || gapOut || wakeHit) begin
			pulses_reg <= 2'h0;
			gap_reg <= '0;
		end else if (pulseOk) begin
			pulses_reg <= pulses_reg + 2'h1;
			gap_reg <= '0;
		end else if (pulses_reg != 2'h0 && !wakeSense) begin
			gap_reg <= gap_reg + 1'b1;
		end
	end

	// Sticky wake flag; set wins over the clearing bus-mode change
	always_ff @(posedge ref_clk) begin
		if (srst)
			wakeFlag <= 1'b0;
		else if (wakeHit)
			wakeFlag <= 1'b1;
		else if (busActive)
			wakeFlag <= 1'b0;
	end

	// Mode sequencer: stop, hold after select wake, normal after service
	logic [cwd_pkg::CNT_W-1:0] modeCnt_reg;
	logic csWake;
	assign csWake = csHigh & ~csHigh_reg;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			mode <= cwd_pkg::MODE_STOP;
			modeCnt_reg <= '0;
			mainRegulatorOutput <= 1'b0;
			resetReleased <= 1'b0;
		end else begin
			unique case (mode)
				cwd_pkg::MODE_STOP: begin
					if (modeCnt_reg != '0) begin
						if (modeCnt_reg == H_DLY) begin
							mode <= cwd_pkg::MODE_HOLD;
							modeCnt_reg <= '0;
							mainRegulatorOutput <= 1'b1;
							resetReleased <= 1'b1;
						end else
							modeCnt_reg <= modeCnt_reg + 1'b1;
					end else if (csWake)
						modeCnt_reg <= 20'h00001;
				end
				cwd_pkg::MODE_HOLD: begin
					if (modeCnt_reg != '0) begin
						if (modeCnt_reg == N_DLY) begin
							mode <= cwd_pkg::MODE_NORMAL;
							modeCnt_reg <= '0;
						end else
							modeCnt_reg <= modeCnt_reg + 1'b1;
					end else if (watchdogService)
						modeCnt_reg <= 20'h00001;
				end
				cwd_pkg::MODE_NORMAL: begin
					modeCnt_reg <= '0;
				end
				default: begin
					mode <= cwd_pkg::MODE_STOP;
					modeCnt_reg <= '0;
				end
			endcase
		end
	end

	// Bus mode change applied after a fixed latency of BUSMODE_DLY_CYC cycles
	logic [cwd_pkg::CNT_W-1:0] busCnt_reg;
	logic busPend_reg;
	logic busTarget_reg;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			busActive <= 1'b0;
			busCnt_reg <= '0;
			busPend_reg <= 1'b0;
			busTarget_reg <= 1'b0;
		end else if (busCmd.modeValid && mode == cwd_pkg::MODE_NORMAL) begin
			busPend_reg <= 1'b1;
			busTarget_reg <= busCmd.active;
			busCnt_reg <= '0;
		end else if (busPend_reg) begin
			if (busCnt_reg == B_DLY - 1'b1) begin
				busActive <= busTarget_reg;
				busPend_reg <= 1'b0;
			end else
				busCnt_reg <= busCnt_reg + 1'b1;
		end
	end

	// Low interrupt pulse on wake while in stop
	logic [cwd_pkg::CNT_W-1:0] intCnt_reg;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			intPinN <= 1'b1;
			intCnt_reg <= '0;
		end else if (wakeHit && mode == cwd_pkg::MODE_STOP) begin
			intPinN <= 1'b0;
			intCnt_reg <= '0;
		end else if (!intPinN) begin
			if (intCnt_reg == I_LEN - 1'b1)
				intPinN <= 1'b1;
			else
				intCnt_reg <= intCnt_reg + 1'b1;
		end
	end

	// Transmit path; a stuck dominant transmitter is cut off
	logic [cwd_pkg::CNT_W-1:0] domCnt_reg;
	logic domLock;
	assign domLock = domCnt_reg >= D_TOUT;
	always_ff @(posedge ref_clk) begin
		if (srst || !txDom)
			domCnt_reg <= '0;
		else if (!domLock)
			domCnt_reg <= domCnt_reg + 1'b1;
	end
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			busDrive <= 1'b0;
			rxPin <= 1'b1;
		end else begin
			busDrive <= busActive & txDom & ~domLock;
			rxPin <= ~busDom;
		end
	end
endmodule

//--- testbench/cwd_bus_node.sv
`timescale 1ns/100ps
module cwd_bus_node (
	input wire logic ref_clk,
	input wire logic busDrive,
	output logic busDomPin
);
	logic nodeDom_reg = 1'h0;
	// Wired bus: dominant while any node drives it
	assign busDomPin = nodeDom_reg | busDrive;
	// One dominant pulse of w cycles, then g recessive cycles
	task automatic send(input int w, input int g);
		@(posedge ref_clk) nodeDom_reg <= 1'h1;
		repeat (w) @(posedge ref_clk);
		nodeDom_reg <= 1'h0;
		repeat (g) @(posedge ref_clk);
	endtask
endmodule

//--- testbench/cwd_can_wake_sva.sv
`timescale 1ns/100ps
module cwd_can_wake_sva #(
	parameter int BUSMODE_DLY_CYC = 10,
	parameter int INT_PULSE_CYC = 10,
	parameter int DOM_TOUT_CYC = 200
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic busDomPin,
	input wire logic chipSelPin,
	input wire logic watchdogService,
	input wire cwd_pkg::cwd_bus_cmd_t busCmd,
	input wire logic busWakeDisable,
	input wire logic busDrive,
	input wire logic rxPin,
	input wire logic wakeFlag,
	input wire logic intPinN,
	input wire logic mainRegulatorOutput,
	input wire logic resetReleased,
	input wire cwd_pkg::cwd_mode_t mode,
	input wire logic busActive
);
	// Mode delay windows in cycles; too long for delay ranges, so counters
	localparam int HOLD_MIN = 15 * cwd_pkg::CLK_MHZ;
	localparam int HOLD_MAX = 90 * cwd_pkg::CLK_MHZ;
	localparam int NORM_MIN = 15 * cwd_pkg::CLK_MHZ;
	localparam int NORM_MAX = 70 * cwd_pkg::CLK_MHZ;
	// Sync stages and counter load give a few cycles of slack
	localparam int BM_HI = BUSMODE_DLY_CYC + 2;
	localparam int INT_LAST = INT_PULSE_CYC - 1;
	int domCnt_reg;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// Length of the current dominant drive
	always_ff @(posedge ref_clk) begin
		domCnt_reg <= (srst || !busDrive) ? 0 : domCnt_reg + 1;
	end
	// Cycles since a select wake in stop
	int holdWait_reg;
	always_ff @(posedge ref_clk) begin
		if (srst || mode != cwd_pkg::MODE_STOP)
			holdWait_reg <= 0;
		else if (holdWait_reg != 0 || $rose(chipSelPin))
			holdWait_reg <= holdWait_reg + 1;
	end
	// Cycles since a service command in hold
	int normWait_reg;
	always_ff @(posedge ref_clk) begin
		if (srst || mode != cwd_pkg::MODE_HOLD)
			normWait_reg <= 0;
		else if (normWait_reg != 0 || watchdogService)
			normWait_reg <= normWait_reg + 1;
	end
	wake_hold_a: assert property (wakeFlag && !busActive |=> wakeFlag)
		else $error("wake flag dropped");
	wake_off_a: assert property ($rose(wakeFlag) |-> !$past(busWakeDisable))
		else $error("wake while disabled");
	int_start_a: assert property ($fell(intPinN) |-> $rose(wakeFlag) && mode == cwd_pkg::MODE_STOP)
		else $error("interrupt without wake");
	int_width_a: assert property ($fell(intPinN) |-> ##INT_LAST !intPinN ##1 intPinN)
		else $error("interrupt pulse width");
	hold_late_a: assert property (holdWait_reg <= HOLD_MAX)
		else $error("hold mode late");
	hold_early_a: assert property ($rose(resetReleased) |->
		mode == cwd_pkg::MODE_HOLD && mainRegulatorOutput && holdWait_reg >= HOLD_MIN)
		else $error("hold mode early");
	norm_late_a: assert property (normWait_reg <= NORM_MAX)
		else $error("normal mode late");
	norm_early_a: assert property ($changed(mode) && mode == cwd_pkg::MODE_NORMAL |->
		normWait_reg >= NORM_MIN) else $error("normal mode early");
	bus_mode_a: assert property (busCmd.modeValid && busCmd.active && mode == cwd_pkg::MODE_NORMAL |->
		##[1:BM_HI] busActive) else $error("bus mode late");
	rx_level_a: assert property ($stable(busDomPin) [*4] |-> rxPin == !busDomPin)
		else $error("receive level wrong");
	drive_gate_a: assert property (busDrive |-> busActive)
		else $error("drive outside active mode");
	dom_tout_a: assert property (domCnt_reg <= DOM_TOUT_CYC)
		else $error("dominant drive too long");
	cover property ($rose(wakeFlag));
	cover property ($rose(busActive));
	cover property (domCnt_reg == 50);
	cover property ($fell(intPinN));
endmodule
bind cwd_can_wake cwd_can_wake_sva #(.BUSMODE_DLY_CYC(BUSMODE_DLY_CYC),
	.INT_PULSE_CYC(INT_PULSE_CYC),
	.DOM_TOUT_CYC(DOM_TOUT_CYC)) cwd_can_wake_sva_i (.*);

//--- testbench/tb_cwd_can_wake.sv
`timescale 1ns/100ps
module tb_cwd_can_wake;
	logic ref_clk = 1'h0;
	logic srst = 1'h1;
	logic txPin = 1'h1;
	logic chipSelPin = 1'h0;
	logic watchdogService = 1'h0;
	logic busWakeDisable = 1'h1;
	cwd_pkg::cwd_bus_cmd_t busCmd = '0;
	logic busDomPin, busDrive, rxPin, wakeFlag, intPinN, mainRegulatorOutput, resetReleased;
	logic busActive;
	cwd_pkg::cwd_mode_t mode;
	int failCount = 0;
	int totalChecks = 0;
	// Short counts keep the run small; mode delays run at full length
	cwd_can_wake #(.PULSE_MAX_CYC(400), .GAP_MAX_CYC(400),
		.BUSMODE_DLY_CYC(10), .INT_PULSE_CYC(10), .DOM_TOUT_CYC(200)) cwd_can_wake_i (.*);
	cwd_bus_node cwd_bus_node_i (.*);
	// 200 MHz clock
	initial forever #2.5 ref_clk = ~ref_clk;
	task automatic chk(input logic got, input logic exp);
		totalChecks++;
		if (got !== exp) begin
			failCount++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chkMode(input cwd_pkg::cwd_mode_t got, input cwd_pkg::cwd_mode_t exp);
		totalChecks++;
		if (got !== exp) begin
			failCount++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Wait off the edge so outputs have settled
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic pulses(input int n, input int w, input int g);
		repeat (n) cwd_bus_node_i.send(w, g);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", totalChecks, failCount);
		if (failCount == 0 && totalChecks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Watchdog: tests need about 40000 cycles, mostly mode delays
	initial begin
		#300000;
		failCount++;
		summarize();
	end
	initial begin
		wt(4);
		@(posedge ref_clk) srst <= 1'h0;
		wt(2);
		chkMode(mode, cwd_pkg::MODE_STOP);
		chk(intPinN, 1'h1);
		pulses(3, 200, 100);
		chk(wakeFlag, 1'h0);
		@(posedge ref_clk) busWakeDisable <= 1'h0;
		pulses(2, 200, 100);
		pulses(1, 50, 100);
		pulses(2, 200, 100);
		chk(wakeFlag, 1'h0);
		pulses(1, 450, 100);
		pulses(2, 200, 450);
		pulses(2, 200, 100);
		chk(wakeFlag, 1'h0);
		// Long third pulse: spacing counts recessive time only
		pulses(1, 350, 6);
		#1;
		chk(wakeFlag, 1'h1);
		chk(intPinN, 1'h0);
		wt(20);
		chk(intPinN, 1'h1);
		$display("test wake done");
		wt(20 * cwd_pkg::CLK_MHZ);
		@(posedge ref_clk) chipSelPin <= 1'h1;
		wt(14 * cwd_pkg::CLK_MHZ);
		chkMode(mode, cwd_pkg::MODE_STOP);
		chk(resetReleased | mainRegulatorOutput, 1'h0);
		wt(76 * cwd_pkg::CLK_MHZ);
		chkMode(mode, cwd_pkg::MODE_HOLD);
		chk(resetReleased & mainRegulatorOutput, 1'h1);
		chk(wakeFlag, 1'h1);
		@(posedge ref_clk) watchdogService <= 1'h1;
		@(posedge ref_clk) watchdogService <= 1'h0;
		wt(14 * cwd_pkg::CLK_MHZ);
		chkMode(mode, cwd_pkg::MODE_HOLD);
		wt(55 * cwd_pkg::CLK_MHZ);
		chkMode(mode, cwd_pkg::MODE_NORMAL);
		@(posedge ref_clk) busCmd <= '{1'h1, 1'h0, 1'h1};
		@(posedge ref_clk) busCmd <= '0;
		wt(12);
		chk(busActive, 1'h1);
		chk(wakeFlag, 1'h0);
		$display("test modes done");
		@(posedge ref_clk) txPin <= 1'h0;
		wt(20);
		chk(busDrive, 1'h1);
		chk(rxPin, 1'h0);
		wt(200);
		chk(busDrive, 1'h0);
		chk(rxPin, 1'h1);
		@(posedge ref_clk) txPin <= 1'h1;
		$display("test transmit done");
		summarize();
	end
endmodule
